// ### design/flyback_seq_defines.vh
// constants for the flyback fault and mode sequencer
// assumes a 40 MHz system clock; included by the sequencer only
`ifndef FLYBACK_SEQ_DEFINES_VH
`define FLYBACK_SEQ_DEFINES_VH

// --------------------------------------------------------------------
// registers and fields
// --------------------------------------------------------------------
`define ADDR_CTRL        12'h000
`define ADDR_STATUS      12'h004
`define ADDR_FAULTS      12'h008
`define ADDR_ID          12'h00c
`define CTRL_RESET       32'h0000_0000
`define CTRL_VARIANT_BIT 0
`define CTRL_LATCH_BIT   1
`define CTRL_OFFSET_BIT  2
`define CTRL_ENABLE_BIT  3

// --------------------------------------------------------------------
// operating states
// --------------------------------------------------------------------
`define ST_OFF     3'h0
`define ST_STARTUP 3'h1
`define ST_ON      3'h2
`define ST_FAULT   3'h3
`define ST_DISABLE 3'h4

// --------------------------------------------------------------------
// qualification
// --------------------------------------------------------------------
`define OVP_CYCLES   6'h03
`define OTP_CYCLES   6'h20
`define BO_CYCLES    6'h10
`define CLK_MHZ      40
`define BO_TIME_US   1
`define BO_CLKS      (`BO_TIME_US * `CLK_MHZ)

`endif

// ### design/flyback_seq.v
// flyback controller fault qualification and operating mode sequencer
// assumes comparator flags arrive asynchronously from the analog front
// end and that supply power-on reset drives resetn_i
//
// What this block does
// - variant bit picks brown-out sensing or ovp plus otp; disable always
// - brown-out offset current turns on after first brown-in, stays on
// - brown-out fault only after full qualification time below threshold
// - ovp fault after three consecutive switching cycles above threshold
// - otp fault after 32 switching cycles beyond temperature threshold
// - pin below disable level stops switching at once
// - supply below turn-on keeps off state, all but the offset source held disabled
// - supply crossing turn-on moves off to startup
// - after fault or shutdown stay powered until undervoltage turn-off
// - startup clamps to ramp, ends on ramp done or feedback below ramp
// - faults stay active in startup and send device to fault
// - on state selects burst, foldback, fixed or boost from feedback
// - fault state stops switching and enables supply fault sink
// - undervoltage in fault turns off, clears faults, restarts later
// - latched variant resumes only after power-on reset
// - pin below disable enters low-power disabled state
// - leave disabled when pin rises again and no fault pending
// - keep running between undervoltage turn-off and overvoltage lockout
// - auto-restart retries every startup, re-faults if still present
`timescale 1ns/100ps
`include "flyback_seq_defines.vh"

module flyback_seq (
  input  wire        clock_i,
  input  wire        resetn_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // comparator flags (asynchronous)
  input  wire        sw_cycle_i,
  input  wire        vdd_above_on_i,
  input  wire        vdd_below_off_i,
  input  wire        vdd_above_ovlo_i,
  input  wire        flt_below_bo_i,
  input  wire        flt_above_bi_i,
  input  wire        flt_above_ovp_i,
  input  wire        flt_beyond_otp_i,
  input  wire        flt_below_dis_i,
  input  wire        ramp_done_i,
  input  wire        feedback_pin_below_ramp_i,
  input  wire [1:0]  feedback_pin_region_i,
  // outputs
  output reg         switch_en_o,
  output reg         softstart_clamp_o,
  output reg  [1:0]  region_sel_o,
  output reg         fault_sink_en_o,
  output reg         offset_src_en_o,
  output reg         low_power_o,
  output reg         circuits_en_o
);

  parameter [31:0] ID_VALUE = 32'h0000_5a01; // arbitrary value

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  localparam NIN = 12;
  wire [NIN-1:0] raw_in;
  assign raw_in = {sw_cycle_i, vdd_above_on_i, vdd_below_off_i,
                   vdd_above_ovlo_i, flt_below_bo_i, flt_above_bi_i,
                   flt_above_ovp_i, flt_beyond_otp_i, flt_below_dis_i,
                   ramp_done_i, feedback_pin_below_ramp_i, 1'b0};
  reg  [NIN-1:0] s1_r;
  reg  [NIN-1:0] s2_r;
  reg  [NIN-1:0] s3_r;
  reg  [NIN-1:0] q_r;

  // a change counts once second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          q_r[gi]  <= 1'b0;
        end else begin
          s1_r[gi] <= raw_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi])
            q_r[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

  wire cyc_lvl  = q_r[11];
  wire vdd_on   = q_r[10];
  wire vdd_off  = q_r[9];
  wire vdd_ovlo = q_r[8];
  wire bo_low   = q_r[7];
  wire bi_high  = q_r[6];
  wire ovp_hi   = q_r[5];
  wire otp_hit  = q_r[4];
  wire dis_low  = q_r[3];
  wire ramp_dn  = q_r[2];
  wire fb_below = q_r[1];

  // region code is a multi-bit level from the pin side; the whole word
  // must agree in the last two stages, so a skewed change of two bits
  // never shows a code that was not on the pins
  reg [1:0] reg1_r;
  reg [1:0] reg2_r;
  reg [1:0] reg3_r;
  reg [1:0] rsync_r;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg1_r  <= 2'h0;
      reg2_r  <= 2'h0;
      reg3_r  <= 2'h0;
      rsync_r <= 2'h0;
    end else begin
      reg1_r <= feedback_pin_region_i;
      reg2_r <= reg1_r;
      reg3_r <= reg2_r;
      if (reg2_r == reg3_r)
        rsync_r <= reg3_r;
    end
  end

  // one pulse per switching cycle, taken on its rising edge
  reg  cyc_d_r;
  wire cyc_tick = cyc_lvl & ~cyc_d_r;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i)
      cyc_d_r <= 1'b0;
    else
      cyc_d_r <= cyc_lvl;
  end

  // ------------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------------
  reg  [31:0] ctrl_r;
  wire        bo_variant = ctrl_r[`CTRL_VARIANT_BIT];
  wire        latched    = ctrl_r[`CTRL_LATCH_BIT];
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [3:0]  faults_r;  // {ovlo, otp, ovp, brownout}
  reg         latch_mem_r;
  wire        apb_acc = psel_i & penable_i;

  // single-cycle answer: pready high in every access phase
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r    <= `CTRL_RESET;
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      if (psel_i & ~penable_i) begin
        case (paddr_i)
          `ADDR_CTRL:   prdata_o <= ctrl_r;
          `ADDR_STATUS: prdata_o <= {24'h0, latch_mem_r, offset_src_en_o,
                                     region_sel_o, 1'b0, state_r};
          `ADDR_FAULTS: prdata_o <= {28'h0, faults_r};
          `ADDR_ID:     prdata_o <= ID_VALUE;
          default: begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b1;
          end
        endcase
      end
      if (apb_acc & pready_o & pwrite_i & (paddr_i == `ADDR_CTRL))
        ctrl_r <= {28'h0, pwdata_i[3:0]};
    end
  end

  // ------------------------------------------------------------------
  // fault qualifiers
  // ------------------------------------------------------------------
  reg [5:0] ovp_cnt_r;
  reg [5:0] otp_cnt_r;
  reg [5:0] ovlo_cnt_r;
  reg [5:0] bo_cnt_r;
  reg [7:0] bo_pre_r;  // clock prescaler for brown-out qualification
  wire bo_pre_tick = (bo_pre_r == (`BO_CLKS - 1));
  wire in_off      = (state_r == `ST_OFF);

  // count a step of a consecutive qualifier, saturating at its limit
  function [5:0] qual_step;
    input [5:0] cnt;
    input       cond;
    input       tick;
    input [5:0] lim;
    begin
      if (!cond)
        qual_step = 6'h00;
      else if (tick && cnt < lim)
        qual_step = cnt + 6'h01;
      else
        qual_step = cnt;
    end
  endfunction

  // qualifiers stay active in startup too; cleared in off state or when their condition drops
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovp_cnt_r  <= 6'h00;
      otp_cnt_r  <= 6'h00;
      ovlo_cnt_r <= 6'h00;
      bo_cnt_r   <= 6'h00;
      bo_pre_r   <= 8'h00;
    end else if (in_off) begin
      ovp_cnt_r  <= 6'h00;
      otp_cnt_r  <= 6'h00;
      ovlo_cnt_r <= 6'h00;
      bo_cnt_r   <= 6'h00;
      bo_pre_r   <= 8'h00;
    end else begin
      ovp_cnt_r  <= qual_step(ovp_cnt_r, ovp_hi & ~bo_variant,
                              cyc_tick, `OVP_CYCLES);
      otp_cnt_r  <= qual_step(otp_cnt_r, otp_hit & ~bo_variant,
                              cyc_tick, `OTP_CYCLES);
      ovlo_cnt_r <= qual_step(ovlo_cnt_r, vdd_ovlo,
                              cyc_tick, `OVP_CYCLES);
      bo_cnt_r   <= qual_step(bo_cnt_r, bo_low & bo_variant,
                              bo_pre_tick, `BO_CYCLES);
      bo_pre_r   <= bo_pre_tick ? 8'h00 : bo_pre_r + 8'h01;
    end
  end

  // variant decides which pin qualifiers can fire
  wire [3:0] qual_hit = {ovlo_cnt_r == `OVP_CYCLES,
                         otp_cnt_r  == `OTP_CYCLES,
                         ovp_cnt_r  == `OVP_CYCLES,
                         bo_cnt_r   == `BO_CYCLES};
  wire any_fault = |qual_hit;

  // ------------------------------------------------------------------
  // fault memory and offset source
  // ------------------------------------------------------------------
  // latched memory survives undervoltage; only power-on reset clears it
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      faults_r        <= 4'h0;
      latch_mem_r     <= 1'b0;
      offset_src_en_o <= 1'b0;
    end else begin
      if (in_off)
        faults_r <= 4'h0;
      else
        faults_r <= faults_r | qual_hit;
      if (any_fault & latched)
        latch_mem_r <= 1'b1;
      if (bo_variant & bi_high & ~in_off)
        offset_src_en_o <= 1'b1;
      else if (~bo_variant)
        offset_src_en_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // operating state machine
  // ------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `ST_OFF: begin
        if (vdd_on & ~vdd_off & ~latch_mem_r)
          state_nxt = `ST_STARTUP;
      end
      `ST_STARTUP: begin
        if (vdd_off)
          state_nxt = `ST_OFF;
        else if (any_fault)
          state_nxt = `ST_FAULT;
        else if (dis_low)
          state_nxt = `ST_DISABLE;
        else if (ramp_dn | fb_below)
          state_nxt = `ST_ON;
      end
      `ST_ON: begin
        if (vdd_off)
          state_nxt = `ST_OFF;
        else if (any_fault)
          state_nxt = `ST_FAULT;
        else if (dis_low)
          state_nxt = `ST_DISABLE;
      end
      `ST_FAULT: begin
        if (vdd_off)
          state_nxt = `ST_OFF;
      end
      `ST_DISABLE: begin
        if (vdd_off)
          state_nxt = `ST_OFF;
        else if (any_fault)
          state_nxt = `ST_FAULT;
        else if (~dis_low)
          state_nxt = `ST_STARTUP;
      end
      default: state_nxt = `ST_OFF;
    endcase
  end

  // state register plus registered outputs
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r           <= `ST_OFF;
      switch_en_o       <= 1'b0;
      softstart_clamp_o <= 1'b0;
      region_sel_o      <= 2'h0;
      fault_sink_en_o   <= 1'b0;
      low_power_o       <= 1'b0;
      circuits_en_o     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // disable pin cuts switching with no qualification at all
      switch_en_o <= ctrl_r[`CTRL_ENABLE_BIT] & ~dis_low &
                     ~any_fault & ~vdd_off &
                     ((state_nxt == `ST_STARTUP) |
                      (state_nxt == `ST_ON));
      softstart_clamp_o <= (state_nxt == `ST_STARTUP);
      region_sel_o      <= (state_nxt == `ST_ON) ?
                           rsync_r : 2'h0;
      fault_sink_en_o   <= (state_nxt == `ST_FAULT);
      low_power_o       <= (state_nxt == `ST_DISABLE);
      circuits_en_o     <= (state_nxt != `ST_OFF);
    end
  end

endmodule // flyback_seq

// ### testbench/flyback_seq_assertions.sv
// concurrent checks on the sequencer ports
// assumes bound to the sequencer; bench stimulus reaches each antecedent
`timescale 1ns/100ps

module flyback_seq_chk (
  input wire       clock_i,
  input wire       resetn_i,
  input wire       psel_i,
  input wire       penable_i,
  input wire       pready_o,
  input wire       vdd_below_off_i,
  input wire       flt_above_bi_i,
  input wire       flt_below_dis_i,
  input wire       switch_en_o,
  input wire       softstart_clamp_o,
  input wire [1:0] region_sel_o,
  input wire       fault_sink_en_o,
  input wire       offset_src_en_o,
  input wire       low_power_o,
  input wire       circuits_en_o
);
  reg [3:0] bi_age_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // cycles since brown-in was last seen, saturating so it never wraps
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i)
      bi_age_r <= 4'hf;
    else if (flt_above_bi_i)
      bi_age_r <= 4'h0;
    else if (bi_age_r != 4'hf)
      bi_age_r <= bi_age_r + 4'h1;
  end

  // zero wait states: setup cycle is answered in the first access cycle
  property p_pready; psel_i && !penable_i |=> pready_o; endproperty
  a_pready: assert property (p_pready) else $error("late pready");
  property p_off;
    !circuits_en_o |-> !(switch_en_o || softstart_clamp_o || fault_sink_en_o
      || low_power_o) && region_sel_o == 2'h0;
  endproperty
  a_off: assert property (p_off) else $error("activity in off");
  property p_clamp;
    softstart_clamp_o |-> circuits_en_o && region_sel_o == 2'h0 && !low_power_o;
  endproperty
  a_clamp: assert property (p_clamp) else $error("bad clamp");
  property p_region;
    region_sel_o != 2'h0 |-> !softstart_clamp_o && !fault_sink_en_o;
  endproperty
  a_region: assert property (p_region) else $error("region off on");
  property p_fault;
    fault_sink_en_o |-> !switch_en_o && !softstart_clamp_o && !low_power_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault switching");
  property p_dis; flt_below_dis_i [*7] |-> !switch_en_o; endproperty
  a_dis: assert property (p_dis) else $error("disable ignored");
  property p_lowp; low_power_o |-> !switch_en_o && !fault_sink_en_o; endproperty
  a_lowp: assert property (p_lowp) else $error("low power busy");
  property p_uvlo; vdd_below_off_i [*7] |-> !circuits_en_o; endproperty
  a_uvlo: assert property (p_uvlo) else $error("no turn-off");
  property p_bi; $rose(offset_src_en_o) |-> bi_age_r < 4'h8; endproperty
  a_bi: assert property (p_bi) else $error("offset before brown-in");
endmodule // flyback_seq_chk

bind flyback_seq flyback_seq_chk flyback_seq_chk_inst (
  .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o),
  .vdd_below_off_i(vdd_below_off_i), .flt_above_bi_i(flt_above_bi_i),
  .flt_below_dis_i(flt_below_dis_i), .switch_en_o(switch_en_o),
  .softstart_clamp_o(softstart_clamp_o), .region_sel_o(region_sel_o),
  .fault_sink_en_o(fault_sink_en_o), .offset_src_en_o(offset_src_en_o),
  .low_power_o(low_power_o), .circuits_en_o(circuits_en_o));

// ### testbench/analog_front.sv
// comparator and switching-cycle model of the analog side
// assumes the bench sets pin levels in millivolts at clock edges
`timescale 1ns/100ps

module analog_front (
  input  wire        clock_i,
  input  wire        switch_en_i,
  input  wire [15:0] vdd_mv_i,
  input  wire [15:0] flt_mv_i,
  output wire        sw_cycle_o,
  output wire [7:0]  flags_o
);
  reg [3:0] ph_r = 4'h0;

  // 16-clock switching period; no gate edges while switching is stopped
  always @(posedge clock_i) begin
    if (switch_en_i)
      ph_r <= ph_r + 4'h1;
  end
  assign sw_cycle_o = switch_en_i & ph_r[3];
  // on, off, ovlo, brown-out, brown-in, ovp, otp, disable
  assign flags_o = {vdd_mv_i > 16'h3bc4, vdd_mv_i < 16'h2328,
                    vdd_mv_i > 16'h6d60, flt_mv_i < 16'h0578,
                    flt_mv_i > 16'h05aa, flt_mv_i > 16'h0fa0,
                    flt_mv_i < 16'h03e8, flt_mv_i < 16'h01f4};
endmodule // analog_front

// ### testbench/tb_top.sv
// self-checking bench for the flyback fault and mode sequencer
// assumes analog_front supplies the supply and fault-pin flags and switching cycles; the bench drives ramp and feedback
`timescale 1ns/100ps

module tb_top;
  localparam [31:0] ID = 32'h0000_3c5e; // arbitrary identity value
  reg         clock_i = 1'b0;
  reg         resetn_i = 1'b0;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg  [15:0] vdd_mv = 16'h0, flt_mv = 16'h07d0;
  reg         ramp = 1'b0, fb_low = 1'b0;
  reg  [1:0]  region = 2'h0;
  wire [31:0] prdata;
  wire [7:0]  fl;
  wire [1:0]  rsel;
  wire        pready, pslverr, sw, sw_en, clamp, sink, offs, lowp, circ;
  integer     error_cnt = 0, total_checks = 0, cyc_cnt = 0;

  flyback_seq #(.ID_VALUE(ID)) flyback_seq_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sw_cycle_i(sw), .vdd_above_on_i(fl[7]),
    .vdd_below_off_i(fl[6]), .vdd_above_ovlo_i(fl[5]),
    .flt_below_bo_i(fl[4]), .flt_above_bi_i(fl[3]), .flt_above_ovp_i(fl[2]),
    .flt_beyond_otp_i(fl[1]), .flt_below_dis_i(fl[0]), .ramp_done_i(ramp),
    .feedback_pin_below_ramp_i(fb_low), .feedback_pin_region_i(region),
    .switch_en_o(sw_en), .softstart_clamp_o(clamp), .region_sel_o(rsel),
    .fault_sink_en_o(sink), .offset_src_en_o(offs), .low_power_o(lowp),
    .circuits_en_o(circ));
  analog_front analog_front_inst (.clock_i(clock_i), .switch_en_i(sw_en),
    .vdd_mv_i(vdd_mv), .flt_mv_i(flt_mv), .sw_cycle_o(sw), .flags_o(fl));

  // 40 MHz clock
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d, input [31:0] e,
           input er);
    begin
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      // only pready or the hang guard ends a wait for the answer
      @(posedge clock_i);
      while (pready !== 1'b1)
        @(posedge clock_i);
      psel <= 1'b0;
      penable <= 1'b0;
      if (!w)
        chk(prdata, e);
      chk({30'h0, pready, pslverr}, {30'h0, 1'b1, er});
    end
  endtask
  // flags need five edges to reach the outputs, eight leaves margin
  task st(input [4:0] e);
    begin
      repeat (8) @(posedge clock_i);
      chk({27'h0, sw_en, clamp, sink, lowp, circ}, {27'h0, e});
    end
  endtask
  task vdd(input [15:0] v, input [4:0] e);
    begin
      @(posedge clock_i);
      vdd_mv <= v;
      st(e);
    end
  endtask
  task flt(input [15:0] v, input [4:0] e);
    begin
      @(posedge clock_i);
      flt_mv <= v;
      st(e);
    end
  endtask
  // pin level held across exactly n gate rises, changed mid-pulse
  task pulse(input [15:0] v, input integer n);
    begin
      @(posedge sw);
      repeat (4) @(posedge clock_i);
      flt_mv <= v;
      repeat (n) @(posedge sw);
      repeat (4) @(posedge clock_i);
      flt_mv <= 16'h07d0;
    end
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task t_run;
    integer r;
    begin
      apb(1'b0, 12'h00c, 32'h0, ID, 1'b0);
      apb(1'b1, 12'h000, 32'hffff_ffff, 32'h0, 1'b0);
      apb(1'b0, 12'h000, 32'h0, 32'hf, 1'b0);
      apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'h000, 32'h8, 32'h0, 1'b0);
      st(5'h00);
      vdd(16'h3e80, 5'h19);
      fb_low <= 1'b1;
      st(5'h11);
      for (r = 1; r < 4; r = r + 1) begin
        region <= r[1:0];
        st(5'h11);
        chk({30'h0, rsel}, r);
      end
      region <= 2'h0;
      pulse(16'h1194, 2);
      st(5'h11);
      pulse(16'h1194, 3);
      st(5'h05);
      apb(1'b0, 12'h004, 32'h0, 32'h3, 1'b0);
      apb(1'b0, 12'h008, 32'h0, 32'h2, 1'b0);
      fb_low <= 1'b0;
      vdd(16'h2ee0, 5'h05);
      vdd(16'h1f40, 5'h00);
      vdd(16'h3e80, 5'h19);
    end
  endtask
  task t_prot;
    begin
      pulse(16'h0320, 31);
      pulse(16'h0320, 31);
      st(5'h19);
      pulse(16'h0320, 32);
      st(5'h05);
      vdd(16'h1f40, 5'h00);
      vdd(16'h3e80, 5'h19);
      flt(16'h012c, 5'h03);
      flt(16'h07d0, 5'h19);
      vdd(16'h6590, 5'h19);
      // supply above lockout: three switching cycles, then fault
      vdd_mv <= 16'h7530;
      repeat (80) @(posedge clock_i);
      st(5'h05);
      apb(1'b0, 12'h008, 32'h0, 32'h8, 1'b0);
      vdd(16'h1f40, 5'h00);
      vdd(16'h3e80, 5'h19);
    end
  endtask
  task t_bo;
    begin
      flt(16'h058c, 5'h19);
      apb(1'b1, 12'h000, 32'h9, 32'h0, 1'b0);
      st(5'h19);
      chk({31'h0, offs}, 32'h0);
      flt(16'h07d0, 5'h19);
      flt(16'h058c, 5'h19);
      chk({31'h0, offs}, 32'h1);
      pulse(16'h1194, 3);
      st(5'h19);
      flt_mv <= 16'h0514;
      repeat (300) @(posedge clock_i);
      flt(16'h07d0, 5'h19);
      flt_mv <= 16'h0514;
      repeat (760) @(posedge clock_i);
      flt(16'h07d0, 5'h05);
      vdd(16'h1f40, 5'h00);
      vdd(16'h3e80, 5'h19);
      // ramp completion alone also ends startup
      ramp <= 1'b1;
      st(5'h11);
      ramp <= 1'b0;
    end
  endtask
  task t_latch;
    begin
      apb(1'b1, 12'h000, 32'ha, 32'h0, 1'b0);
      pulse(16'h1194, 3);
      st(5'h05);
      vdd(16'h1f40, 5'h00);
      vdd(16'h3e80, 5'h00);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      resetn_i <= 1'b1;
      st(5'h09);
      apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
    end
  endtask

  // hang guard: a stuck wait ends the run as a failure
  always @(posedge clock_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_run;
    t_prot;
    t_bo;
    t_latch;
    end_sim;
  end
endmodule // tb_top
